// [hw/rf_status_cfg_pkg.sv]
// Constants of the RF front-end status and configuration register bank.
// Assumes registers are split over two spaces, selected beside the address.
package rf_status_cfg_pkg;

  // ----------------------------------------------------------------
  // Register offsets, space A
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_GAIN_STATE = 8'h2E;
  localparam logic [7:0] ADDR_CAP_CTRL = 8'h2F;
  localparam logic [7:0] ADDR_CAP_DISP = 8'h30;
  localparam logic [7:0] ADDR_AUX_DISP = 8'h31;

  // ----------------------------------------------------------------
  // Register offsets, space B
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_OVER_HI = 8'h30;
  localparam logic [7:0] ADDR_OVER_LO = 8'h31;
  localparam logic [7:0] ADDR_UNDER_HI = 8'h32;
  localparam logic [7:0] ADDR_UNDER_LO = 8'h33;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h3E;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h3F;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int CAP_MCAL_LSB = 3;
  localparam int CAP_MCAL_W = 5;
  localparam int CAP_GAIN_W = 3;
  localparam int DRIVE_LSB = 6;
  localparam int SEQ_HI_W = 6;
  localparam int SEQ_W = 14;

  // Drive level codes
  localparam logic [1:0] DRIVE_DRIVER_SUPPLY = 2'h0;
  localparam logic [1:0] DRIVE_MOD_SUPPLY = 2'h1;
  localparam logic [1:0] DRIVE_STOP = 2'h2;

  // Interrupt event bits
  localparam int EV_W = 5;
  localparam int EV_CAL_END = 0;
  localparam int EV_CAL_ERR = 1;
  localparam int EV_EXT_FIELD = 2;
  localparam int EV_OSC_OK = 3;
  localparam int EV_RX_DONE = 4;

  // Synchroniser vector layout
  localparam int SYNC_W = 25;
  localparam int S_AM_LSB = 21;
  localparam int S_PM_LSB = 17;
  localparam int S_CAL_LSB = 12;
  localparam int S_CAL_END = 11;
  localparam int S_CAL_ERR = 10;
  localparam int S_CHA = 9;
  localparam int S_EFD = 8;
  localparam int S_TX = 7;
  localparam int S_TX_CA = 6;
  localparam int S_OSC_RUN = 5;
  localparam int S_OSC_STAB = 4;
  localparam int S_RX_EN = 3;
  localparam int S_RX_ACT = 2;
  localparam int S_PEER = 1;
  localparam int S_COLL = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [SYNC_W-1:0] SYNC_RST = 25'h000_0008;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [EV_W-1:0] EV_RST = 5'h00;

endpackage : rf_status_cfg_pkg

// [hw/rf_status_cfg_regs.sv]
// Status and configuration register bank of an NFC reader RF front end.
// Assumes status inputs come from analog or other-domain logic and are
// synchronised here; registers are reached over a plain strobe port.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps

// Function
// - Gain state bits 7..4 report the combined AM gain cut, read-only.
// - Gain state bits 3..0 report the combined PM gain cut, read-only.
// - Cap sensor control bits 7..3 hold the binary weighted manual calibration value.
// - A zero manual calibration value selects automatic calibration.
// - Cap sensor control bits 2..0 hold the sensor gain code for the sensor.
// - Cap sensor display shows result, end and error flags, bit 0 reads zero.
// - Aux bit 7 shows the receive channel, 0 for AM and 1 for PM.
// - Aux bit 6 mirrors the external field detector output.
// - Aux bit 5 shows transmission, except collision avoidance sends.
// - Aux bit 4 is 1 only with the oscillator running and stable.
// - Aux bit 3 shows the receive decoder enabled and is 1 after reset.
// - Aux bit 2 shows the decoder receiving a message.
// - Aux bit 1 shows peer detection mode, bit 0 collision avoidance mode.
// - The overshoot drive level selects the drive used where its sequence bit is 1.
// - The undershoot drive level selects the drive used where its sequence bit is 1.
module rf_status_cfg_regs
  import rf_status_cfg_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_SPACE_B,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // Receiver gain state
  input wire logic [3:0] AM_GAIN_CUT_STATE,
  input wire logic [3:0] PM_GAIN_CUT_STATE,
  // Capacitive sensor
  input wire logic [CAP_MCAL_W-1:0] CAP_CAL_RESULT,
  input wire logic CAP_CAL_END,
  input wire logic CAP_CAL_ERR,
  output logic [CAP_MCAL_W-1:0] CAP_MANUAL_CAL,
  output logic CAP_AUTO_CAL,
  output logic [CAP_GAIN_W-1:0] CAP_GAIN,
  // Activity status
  input wire logic RX_CHANNEL_PM,
  input wire logic EXT_FIELD,
  input wire logic TX_ACTIVE,
  input wire logic TX_COLL_AVOID,
  input wire logic OSC_RUNNING,
  input wire logic OSC_STABLE,
  input wire logic RX_DEC_ENABLED,
  input wire logic RX_RECEIVING,
  input wire logic DETECTOR_PEER_MODE,
  input wire logic DETECTOR_COLLISION_MODE,
  // Wave shaping protection
  output logic [1:0] OVER_DRIVE_LEVEL,
  output logic [SEQ_W-1:0] OVER_SHAPE_SEQ,
  output logic [1:0] UNDER_DRIVE_LEVEL,
  output logic [SEQ_W-1:0] UNDER_SHAPE_SEQ,
  // Interrupt
  output logic IRQ
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] async_in;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;

  assign async_in = {AM_GAIN_CUT_STATE, PM_GAIN_CUT_STATE, CAP_CAL_RESULT,
                     CAP_CAL_END, CAP_CAL_ERR, RX_CHANNEL_PM, EXT_FIELD,
                     TX_ACTIVE, TX_COLL_AVOID, OSC_RUNNING, OSC_STABLE,
                     RX_DEC_ENABLED, RX_RECEIVING, DETECTOR_PEER_MODE,
                     DETECTOR_COLLISION_MODE};

  // Decoder-enable stage resets to 1
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_q <= SYNC_RST;
      sync2_q <= SYNC_RST;
    end else begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // Display register contents
  // ----------------------------------------------------------------
  logic [7:0] gain_state;
  logic [7:0] cap_disp;
  logic [7:0] aux_disp;

  assign gain_state[7:4] = sync2_q[S_AM_LSB +: 4];
  assign gain_state[3:0] = sync2_q[S_PM_LSB +: 4];

  assign cap_disp[7:3] = sync2_q[S_CAL_LSB +: CAP_MCAL_W];
  assign cap_disp[2] = sync2_q[S_CAL_END];
  assign cap_disp[1] = sync2_q[S_CAL_ERR];
  assign cap_disp[0] = 1'b0;

  assign aux_disp[7] = sync2_q[S_CHA];
  assign aux_disp[6] = sync2_q[S_EFD];
  assign aux_disp[5] = sync2_q[S_TX] & ~sync2_q[S_TX_CA];
  assign aux_disp[4] = sync2_q[S_OSC_RUN] & sync2_q[S_OSC_STAB];
  assign aux_disp[3] = sync2_q[S_RX_EN];
  assign aux_disp[2] = sync2_q[S_RX_ACT];
  assign aux_disp[1] = sync2_q[S_PEER];
  assign aux_disp[0] = sync2_q[S_COLL];

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  logic wr_cap_ctrl;
  logic wr_over_hi;
  logic wr_over_lo;
  logic wr_under_hi;
  logic wr_under_lo;
  logic wr_irq_status;
  logic wr_irq_mask;

  assign wr_cap_ctrl = REG_WR & ~REG_SPACE_B & (REG_ADDR == ADDR_CAP_CTRL);
  assign wr_over_hi = REG_WR & REG_SPACE_B & (REG_ADDR == ADDR_OVER_HI);
  assign wr_over_lo = REG_WR & REG_SPACE_B & (REG_ADDR == ADDR_OVER_LO);
  assign wr_under_hi = REG_WR & REG_SPACE_B & (REG_ADDR == ADDR_UNDER_HI);
  assign wr_under_lo = REG_WR & REG_SPACE_B & (REG_ADDR == ADDR_UNDER_LO);
  assign wr_irq_status = REG_WR & REG_SPACE_B & (REG_ADDR == ADDR_IRQ_STATUS);
  assign wr_irq_mask = REG_WR & REG_SPACE_B & (REG_ADDR == ADDR_IRQ_MASK);

  // ----------------------------------------------------------------
  // Capacitive sensor control
  // ----------------------------------------------------------------
  logic [7:0] cap_ctrl_q;
  logic auto_cal_q;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      cap_ctrl_q <= CFG_RST;
    end else if (wr_cap_ctrl) begin
      cap_ctrl_q <= REG_WDATA;
    end
  end

  // Zero manual value hands calibration to the sensor itself
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      auto_cal_q <= 1'b1;
    end else if (wr_cap_ctrl) begin
      auto_cal_q <= (REG_WDATA[CAP_MCAL_LSB +: CAP_MCAL_W] == '0);
    end
  end

  assign CAP_MANUAL_CAL = cap_ctrl_q[CAP_MCAL_LSB +: CAP_MCAL_W];
  assign CAP_AUTO_CAL = auto_cal_q;
  assign CAP_GAIN = cap_ctrl_q[CAP_GAIN_W-1:0];

  // ----------------------------------------------------------------
  // Wave shaping protection
  // ----------------------------------------------------------------
  logic [7:0] over_hi_q;
  logic [7:0] over_lo_q;
  logic [7:0] under_hi_q;
  logic [7:0] under_lo_q;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      over_hi_q <= CFG_RST;
    end else if (wr_over_hi) begin
      over_hi_q <= REG_WDATA;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      over_lo_q <= CFG_RST;
    end else if (wr_over_lo) begin
      over_lo_q <= REG_WDATA;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      under_hi_q <= CFG_RST;
    end else if (wr_under_hi) begin
      under_hi_q <= REG_WDATA;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      under_lo_q <= CFG_RST;
    end else if (wr_under_lo) begin
      under_lo_q <= REG_WDATA;
    end
  end

  // Reserved level code is passed on unchanged
  assign OVER_DRIVE_LEVEL = over_hi_q[DRIVE_LSB +: 2];
  assign UNDER_DRIVE_LEVEL = under_hi_q[DRIVE_LSB +: 2];
  assign OVER_SHAPE_SEQ = {over_hi_q[SEQ_HI_W-1:0], over_lo_q};
  assign UNDER_SHAPE_SEQ = {under_hi_q[SEQ_HI_W-1:0], under_lo_q};

  // ----------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------
  logic [EV_W-1:0] lvl;
  logic [EV_W-1:0] lvl_prev_q;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] irq_status_q;
  logic [EV_W-1:0] irq_mask_q;
  logic irq_q;

  assign lvl[EV_CAL_END] = sync2_q[S_CAL_END];
  assign lvl[EV_CAL_ERR] = sync2_q[S_CAL_ERR];
  assign lvl[EV_EXT_FIELD] = sync2_q[S_EFD];
  assign lvl[EV_OSC_OK] = aux_disp[4];
  assign lvl[EV_RX_DONE] = ~sync2_q[S_RX_ACT];

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      lvl_prev_q <= '1;
    end else begin
      lvl_prev_q <= lvl;
    end
  end

  // Rising edges; receive done is the fall of receiving
  assign ev = lvl & ~lvl_prev_q;

  // Set beats a write-one clear in the same cycle
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_status_q <= EV_RST;
    end else begin
      irq_status_q <= (irq_status_q & ~(wr_irq_status ? REG_WDATA[EV_W-1:0] : EV_RST)) | ev;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_mask_q <= EV_RST;
    end else if (wr_irq_mask) begin
      irq_mask_q <= REG_WDATA[EV_W-1:0];
    end
  end

  // Mask bit 1 enables its event
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_status_q & irq_mask_q);
    end
  end

  assign IRQ = irq_q;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] rd_d;
  logic [7:0] rdata_q;

  always_comb begin
    rd_d = 8'h00;
    if (!REG_SPACE_B) begin
      unique case (REG_ADDR)
        ADDR_GAIN_STATE: rd_d = gain_state;
        ADDR_CAP_CTRL: rd_d = cap_ctrl_q;
        ADDR_CAP_DISP: rd_d = cap_disp;
        ADDR_AUX_DISP: rd_d = aux_disp;
        default: rd_d = 8'h00;
      endcase
    end else begin
      unique case (REG_ADDR)
        ADDR_OVER_HI: rd_d = over_hi_q;
        ADDR_OVER_LO: rd_d = over_lo_q;
        ADDR_UNDER_HI: rd_d = under_hi_q;
        ADDR_UNDER_LO: rd_d = under_lo_q;
        ADDR_IRQ_STATUS: rd_d = {3'h0, irq_status_q};
        ADDR_IRQ_MASK: rd_d = {3'h0, irq_mask_q};
        default: rd_d = 8'h00;
      endcase
    end
  end

  // Data valid only in the cycle after the read strobe
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= REG_RD ? rd_d : 8'h00;
    end
  end

  assign REG_RDATA = rdata_q;

endmodule : rf_status_cfg_regs

// [tb/rf_status_cfg_assertions.sv]
// Port-level checks of the RF status and config register bank.
// Bound to rf_status_cfg_regs; one clock, async active-low reset.
`timescale 1ns/10ps
module rf_status_cfg_assertions
  import rf_status_cfg_pkg::*;
(
  // Clock, reset, register port
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_SPACE_B,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  // Status in, config out
  input wire logic [3:0] AM_GAIN_CUT_STATE,
  input wire logic [3:0] PM_GAIN_CUT_STATE,
  input wire logic [CAP_MCAL_W-1:0] CAP_MANUAL_CAL,
  input wire logic CAP_AUTO_CAL,
  input wire logic [CAP_GAIN_W-1:0] CAP_GAIN,
  input wire logic [1:0] OVER_DRIVE_LEVEL,
  input wire logic [SEQ_W-1:0] OVER_SHAPE_SEQ,
  input wire logic [1:0] UNDER_DRIVE_LEVEL,
  input wire logic [SEQ_W-1:0] UNDER_SHAPE_SEQ
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);
  wire logic wr_a = REG_WR && !REG_SPACE_B;
  wire logic wr_b = REG_WR && REG_SPACE_B;
  a_cap_write: assert property (
    wr_a && REG_ADDR == ADDR_CAP_CTRL |=> {CAP_MANUAL_CAL, CAP_GAIN} == $past(REG_WDATA))
    else $error("Cap control not taken");
  a_auto_cal: assert property (CAP_AUTO_CAL == (CAP_MANUAL_CAL == 5'h00))
    else $error("Auto calibration flag wrong");
  a_over_hi: assert property (
    wr_b && REG_ADDR == ADDR_OVER_HI |=>
    {OVER_DRIVE_LEVEL, OVER_SHAPE_SEQ[13:8]} == $past(REG_WDATA))
    else $error("Overshoot high byte not taken");
  a_over_lo: assert property (
    wr_b && REG_ADDR == ADDR_OVER_LO |=> OVER_SHAPE_SEQ[7:0] == $past(REG_WDATA))
    else $error("Overshoot low byte not taken");
  a_under_hi: assert property (
    wr_b && REG_ADDR == ADDR_UNDER_HI |=>
    {UNDER_DRIVE_LEVEL, UNDER_SHAPE_SEQ[13:8]} == $past(REG_WDATA))
    else $error("Undershoot high byte not taken");
  a_under_lo: assert property (
    wr_b && REG_ADDR == ADDR_UNDER_LO |=> UNDER_SHAPE_SEQ[7:0] == $past(REG_WDATA))
    else $error("Undershoot low byte not taken");
  a_cfg_hold: assert property (!REG_WR |=> $stable({CAP_MANUAL_CAL, CAP_GAIN,
    OVER_DRIVE_LEVEL, OVER_SHAPE_SEQ, UNDER_DRIVE_LEVEL, UNDER_SHAPE_SEQ}))
    else $error("Config changed without write");
  a_gain_read: assert property (
    $stable({AM_GAIN_CUT_STATE, PM_GAIN_CUT_STATE}) [*3] ##0
    (REG_RD && !REG_SPACE_B && REG_ADDR == ADDR_GAIN_STATE) |=>
    REG_RDATA == $past({AM_GAIN_CUT_STATE, PM_GAIN_CUT_STATE}))
    else $error("Gain state read wrong");
endmodule : rf_status_cfg_assertions

bind rf_status_cfg_regs rf_status_cfg_assertions i_chk (
  .MCLK(MCLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_SPACE_B(REG_SPACE_B),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .AM_GAIN_CUT_STATE(AM_GAIN_CUT_STATE), .PM_GAIN_CUT_STATE(PM_GAIN_CUT_STATE),
  .CAP_MANUAL_CAL(CAP_MANUAL_CAL), .CAP_AUTO_CAL(CAP_AUTO_CAL), .CAP_GAIN(CAP_GAIN),
  .OVER_DRIVE_LEVEL(OVER_DRIVE_LEVEL), .OVER_SHAPE_SEQ(OVER_SHAPE_SEQ),
  .UNDER_DRIVE_LEVEL(UNDER_DRIVE_LEVEL), .UNDER_SHAPE_SEQ(UNDER_SHAPE_SEQ));

// [tb/tb.sv]
// Self-checking bench of the RF status and config register bank.
// Drives every port itself; read data is scored through a queue.
`timescale 1ns/10ps
module tb;
  import rf_status_cfg_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and scoring
  // ----------------------------------------------------------------
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic spc_b = 1'b0;
  logic rd_d = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [3:0] am = 4'h0;
  logic [3:0] pm = 4'h0;
  logic [4:0] cal = 5'h00;
  logic [11:0] st = 12'h008;
  logic [7:0] rdata;
  logic [CAP_MCAL_W-1:0] mcal;
  logic autoc;
  logic [CAP_GAIN_W-1:0] gain;
  logic [1:0] ovl;
  logic [1:0] unl;
  logic [SEQ_W-1:0] ovs;
  logic [SEQ_W-1:0] uns;
  logic irq;
  logic [7:0] cc;
  logic [7:0] cfg [4];
  logic [7:0] q [$];
  logic [2:0] gcode [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6};
  int err_total = 0;
  int n_checks = 0;
  int n;

  always #25 mclk = ~mclk;

  rf_status_cfg_regs i_dut (
    .MCLK(mclk), .RST_N(rst_n), .REG_ADDR(addr), .REG_SPACE_B(spc_b), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .AM_GAIN_CUT_STATE(am),
    .PM_GAIN_CUT_STATE(pm), .CAP_CAL_RESULT(cal), .CAP_CAL_END(st[11]), .CAP_CAL_ERR(st[10]),
    .CAP_MANUAL_CAL(mcal), .CAP_AUTO_CAL(autoc), .CAP_GAIN(gain), .RX_CHANNEL_PM(st[9]),
    .EXT_FIELD(st[8]), .TX_ACTIVE(st[7]), .TX_COLL_AVOID(st[6]), .OSC_RUNNING(st[5]),
    .OSC_STABLE(st[4]), .RX_DEC_ENABLED(st[3]), .RX_RECEIVING(st[2]),
    .DETECTOR_PEER_MODE(st[1]), .DETECTOR_COLLISION_MODE(st[0]), .OVER_DRIVE_LEVEL(ovl),
    .OVER_SHAPE_SEQ(ovs), .UNDER_DRIVE_LEVEL(unl), .UNDER_SHAPE_SEQ(uns), .IRQ(irq));

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask : chk

  task automatic bus(input logic w, input logic r, input logic b, input logic [7:0] a,
                     input logic [7:0] d);
    wr <= w;
    rd <= r;
    spc_b <= b;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
  endtask : bus

  task automatic rdx(input logic b, input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    bus(1'b0, 1'b1, b, a, 8'h00);
  endtask : rdx

  task automatic test_done();
    if (err_total == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  // Read data stands only in the cycle after the strobe
  always @(posedge mclk) begin
    if (rd_d) begin
      chk("read data", {8'h00, q.pop_front()}, {8'h00, rdata});
    end
    rd_d <= rd;
  end

  initial begin
    n = $urandom(77);
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    chk("auto cal", 16'h0001, {15'h0000, autoc});
    chk("irq reset", 16'h0000, {15'h0000, irq});
    chk("cap reset", 16'h0000, {8'h00, mcal, gain});
    chk("over reset", 16'h0000, {ovl, ovs});
    chk("under reset", 16'h0000, {unl, uns});
    rdx(0, ADDR_CAP_CTRL, 8'h00);
    for (int k = 0; k < 4; k++) rdx(1, 8'(ADDR_OVER_HI + k), 8'h00);
    rdx(0, 8'h40, 8'h00);
    rdx(1, ADDR_GAIN_STATE, 8'h00);
    rdx(0, ADDR_AUX_DISP, 8'h08);
    for (int i = 0; i < 8; i++) begin
      cc = {5'($urandom), gcode[i % 5]};
      if (i == 0) cc[7:3] = 5'h00;
      for (int k = 0; k < 4; k++) cfg[k] = 8'($urandom);
      cfg[0][7:6] = 2'(i);
      cfg[2][7:6] = 2'(i + 1);
      bus(1, 0, 0, ADDR_CAP_CTRL, cc);
      for (int k = 0; k < 4; k++) bus(1, 0, 1, 8'(ADDR_OVER_HI + k), cfg[k]);
      rdx(0, ADDR_CAP_CTRL, cc);
      for (int k = 0; k < 4; k++) rdx(1, 8'(ADDR_OVER_HI + k), cfg[k]);
      chk("cap out", {7'h00, cc, cc[7:3] == 5'h00}, {7'h00, mcal, gain, autoc});
      chk("over out", {cfg[0], cfg[1]}, {ovl, ovs});
      chk("under out", {cfg[2], cfg[3]}, {unl, uns});
    end
    for (int i = 0; i < 8; i++) begin
      {am, pm, cal, st} <= 25'($urandom);
      bus(1, 0, 0, ADDR_GAIN_STATE, 8'hFF);
      bus(1, 0, 0, ADDR_CAP_DISP, 8'hFF);
      bus(1, 0, 0, ADDR_AUX_DISP, 8'hFF);
      rdx(0, ADDR_GAIN_STATE, {am, pm});
      rdx(0, ADDR_CAP_DISP, {cal, st[11:10], 1'b0});
      rdx(0, ADDR_AUX_DISP, {st[9:8], st[7] & ~st[6], st[5] & st[4], st[3:0]});
    end
    // Interrupt: clear, masked event, unmask, clear again
    st <= 12'h008;
    bus(1, 0, 1, ADDR_IRQ_MASK, 8'h00);
    repeat (3) bus(0, 0, 0, 8'h00, 8'h00);
    bus(1, 0, 1, ADDR_IRQ_STATUS, 8'h1F);
    rdx(1, ADDR_IRQ_STATUS, 8'h00);
    st[8] <= 1'b1;
    repeat (5) bus(0, 0, 0, 8'h00, 8'h00);
    chk("masked irq", 16'h0000, {15'h0000, irq});
    rdx(1, ADDR_IRQ_STATUS, 8'h04);
    bus(1, 0, 1, ADDR_IRQ_MASK, 8'h04);
    for (n = 0; n < 6 && irq !== 1'b1; n++) bus(0, 0, 0, 8'h00, 8'h00);
    chk("irq raised", 16'h0001, {15'h0000, irq});
    if (irq !== 1'b1) test_done();
    bus(1, 0, 1, ADDR_IRQ_STATUS, 8'h04);
    repeat (3) bus(0, 0, 0, 8'h00, 8'h00);
    chk("irq cleared", 16'h0000, {15'h0000, irq});
    rdx(1, ADDR_IRQ_STATUS, 8'h00);
    rdx(1, ADDR_IRQ_MASK, 8'h04);
    // Each event but the external field, which falls here and sets nothing, meets a clear of its own bit on one edge: the set wins
    for (int e = 0; e < EV_W; e++) begin
      if (e == EV_RX_DONE) begin
        st[2] <= 1'b1;
        repeat (4) bus(0, 0, 0, 8'h00, 8'h00);
      end
      case (e)
        EV_CAL_END: st[11] <= 1'b1;
        EV_CAL_ERR: st[10] <= 1'b1;
        EV_EXT_FIELD: st[8] <= 1'b0;
        EV_OSC_OK: st[5:4] <= 2'b11;
        default: st[2] <= 1'b0;
      endcase
      repeat (2) bus(0, 0, 0, 8'h00, 8'h00);
      bus(1, 0, 1, ADDR_IRQ_STATUS, 8'(1 << e));
      rdx(1, ADDR_IRQ_STATUS, (e == EV_EXT_FIELD) ? 8'h00 : 8'(1 << e));
      bus(1, 0, 1, ADDR_IRQ_STATUS, 8'h1F);
    end
    chk("irq masked", 16'h0000, {15'h0000, irq});
    repeat (3) bus(0, 0, 0, 8'h00, 8'h00);
    test_done();
  end
endmodule : tb
